//--- src/eac_pkg.sv
// Purpose: Constants for the nonvolatile byte access controller
// Assumes: 50 MHz core clock
// Notes:   Offsets are I/O register addresses
package eac_pkg;
    // I/O register addresses
    localparam logic [5:0] ADDR_OFS      = 6'h1E;
    localparam logic [5:0] DATA_OFS      = 6'h1D;
    localparam logic [5:0] CTRL_OFS      = 6'h1C;
    // Field layout
    localparam int         ADDR_W        = 6;
    localparam int         DATA_W        = 8;
    localparam int         NVM_DEPTH     = 64;
    localparam int         RD_BIT        = 0;
    localparam int         WR_BIT        = 1;
    // Reset values
    localparam logic [7:0] REG_RST       = 8'h00;
    // Stall lengths in core cycles
    localparam logic [2:0] WR_STALL      = 3'h2;
    localparam logic [2:0] RD_STALL      = 3'h4;
    // Self-timed write duration
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         WR_TIME_HI_NS = 2_500_000;
    localparam int         WR_TIME_LO_NS = 4_000_000;
    localparam int         WR_CYC_HI     = (WR_TIME_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         WR_CYC_LO     = (WR_TIME_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         WR_CNT_W      = 18;
endpackage : eac_pkg

//--- src/eac_nvm_array.sv
// Purpose: Byte array behind the access controller
// Assumes: Single clock, one access per cycle
// Notes:   Read data is registered, valid one cycle after rdEn
`timescale 1ns/1ps
module eac_nvm_array
    import eac_pkg::*;
#(
    parameter int AW    = ADDR_W,
    parameter int DW    = DATA_W,
    parameter int DEPTH = NVM_DEPTH
) (
    // Clock
    input  wire logic          mclk,
    // Access
    input  wire logic          wrEn,
    input  wire logic          rdEn,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[addr] <= wdata;
        end
        if (rdEn) begin
            rdata <= mem[addr];
        end
    end
endmodule : eac_nvm_array

//--- src/eac_access_ctrl.sv
// Purpose: Byte read/write control for the on-chip nonvolatile array
// Assumes: Core reaches registers through I/O address, read and write strobes
// Notes:   Read data of the I/O bus appears one cycle after ioRe
//
// Contract
// - Six-bit address selects one of 64 bytes, linear from 0 to 63.
// - A write stores the data register byte at the addressed location.
// - A read places the addressed byte into the data register.
// - Control register bits 7..2 read as zero.
// - Write strobe stays set for the write time, then clears itself.
// - Setting the write strobe stalls the core for two cycles.
// - Software sets read strobe bit 0; hardware clears it when data ready.
// - A read finishes within one instruction time.
// - Setting the read strobe stalls the core for four cycles.
// - Address, data and control registers sit in the I/O space.
// - Address register bits 7..6 read as zero.
`timescale 1ns/1ps
module eac_access_ctrl
    import eac_pkg::*;
#(
    parameter int WR_CYCLES_HI = WR_CYC_HI,
    parameter int WR_CYCLES_LO = WR_CYC_LO
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // I/O register port
    input  wire logic [5:0] ioAddr,
    input  wire logic       ioWe,
    input  wire logic       ioRe,
    input  wire logic [7:0] ioWdata,
    output logic      [7:0] ioRdata,
    // Core stall
    output logic            cpuStall,
    // Supply level, high when low supply
    input  wire logic       lowSupply
);
    logic [ADDR_W-1:0]   addr_r;
    logic [DATA_W-1:0]   data_r;
    logic                wrStrobe_r;
    logic                rdStrobe_r;
    logic [2:0]          stall_r;
    logic [WR_CNT_W-1:0] wrCnt_r;
    logic [7:0]          rdata_r;
    logic                lowMeta_r;
    logic                lowSync_r;
    logic [DATA_W-1:0]   arrRdata;

    // Register decode
    wire                selAddr  = (ioAddr == ADDR_OFS);
    wire                selData  = (ioAddr == DATA_OFS);
    wire                selCtrl  = (ioAddr == CTRL_OFS);
    wire                ctrlWr   = ioWe && selCtrl;
    wire                wrAccept = ctrlWr && ioWdata[WR_BIT] && !wrStrobe_r;
    wire                rdAccept = ctrlWr && ioWdata[RD_BIT] && !ioWdata[WR_BIT] && !wrStrobe_r;
    wire [7:0]          addrRd   = {2'b00, addr_r};
    wire [7:0]          ctrlRd   = {6'b00_0000, wrStrobe_r, rdStrobe_r};
    wire [7:0]          rdMux    = selAddr ? addrRd : selData ? data_r : selCtrl ? ctrlRd : REG_RST;
    wire [WR_CNT_W-1:0] wrLoad   = lowSync_r ? WR_CNT_W'(WR_CYCLES_LO) : WR_CNT_W'(WR_CYCLES_HI);
    wire                wrDone   = wrStrobe_r && (wrCnt_r == WR_CNT_W'(1));

    assign ioRdata  = rdata_r;
    assign cpuStall = (stall_r != 3'h0);

    // Array: written with the held byte, read at the held address
    eac_nvm_array u_array (
        .mclk  (mclk),
        .wrEn  (wrAccept),
        .rdEn  (rdAccept),
        .addr  (addr_r),
        .wdata (data_r),
        .rdata (arrRdata)
    );

    // Supply level synchroniser
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowMeta_r <= 1'b0;
            lowSync_r <= 1'b0;
        end else begin
            lowMeta_r <= lowSupply;
            lowSync_r <= lowMeta_r;
        end
    end

    // Address and data registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_r <= ADDR_W'(REG_RST);
            data_r <= REG_RST;
        end else begin
            if (ioWe && selAddr) begin
                addr_r <= ioWdata[ADDR_W-1:0];
            end
            if (rdStrobe_r) begin
                data_r <= arrRdata;
            end else if (ioWe && selData) begin
                data_r <= ioWdata;
            end
        end
    end

    // Strobes, write timer and stall counter
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrStrobe_r <= 1'b0;
            rdStrobe_r <= 1'b0;
            wrCnt_r    <= '0;
            stall_r    <= 3'h0;
        end else begin
            rdStrobe_r <= rdAccept;
            if (wrAccept) begin
                wrStrobe_r <= 1'b1;
                wrCnt_r    <= wrLoad;
            end else if (wrDone) begin
                wrStrobe_r <= 1'b0;
                wrCnt_r    <= '0;
            end else if (wrStrobe_r) begin
                wrCnt_r <= wrCnt_r - WR_CNT_W'(1);
            end
            if (wrAccept) begin
                stall_r <= WR_STALL;
            end else if (rdAccept) begin
                stall_r <= RD_STALL;
            end else if (stall_r != 3'h0) begin
                stall_r <= stall_r - 3'h1;
            end
        end
    end

    // Registered read data
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= REG_RST;
        end else if (ioRe) begin
            rdata_r <= rdMux;
        end
    end

    // Write age tracking for checks
    logic [WR_CNT_W-1:0] wrAge_r;
    logic [WR_CNT_W-1:0] wrLen_r;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wrAge_r <= '0;
            wrLen_r <= '0;
        end else if (wrAccept) begin
            wrAge_r <= '0;
            wrLen_r <= wrLoad;
        end else if (wrStrobe_r) begin
            wrAge_r <= wrAge_r + WR_CNT_W'(1);
        end
    end

    // Checks
    sequence sWrStall;
        cpuStall [*2] ##1 !cpuStall;
    endsequence
    sequence sRdStall;
        cpuStall [*4] ##1 !cpuStall;
    endsequence
    sequence sRdDone;
        !rdStrobe_r && (data_r == $past(arrRdata));
    endsequence

    AST_WR_STALL: assert property (@(posedge mclk) disable iff (!rstn)
        wrAccept |=> sWrStall) else $error("write stall not two cycles");
    AST_RD_STALL: assert property (@(posedge mclk) disable iff (!rstn)
        rdAccept |=> sRdStall) else $error("read stall not four cycles");
    AST_RD_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
        rdAccept |=> rdStrobe_r ##1 !rdStrobe_r) else $error("read strobe not cleared");
    AST_RD_DATA: assert property (@(posedge mclk) disable iff (!rstn)
        rdStrobe_r |=> (data_r == $past(arrRdata))) else $error("read byte not in data register");
    AST_CTRL_RSV: assert property (@(posedge mclk) disable iff (!rstn)
        (ioRe && selCtrl) |=> (ioRdata[7:2] == 6'b00_0000)) else $error("control reserved bits not zero");
    AST_ADDR_RSV: assert property (@(posedge mclk) disable iff (!rstn)
        (ioRe && selAddr) |=> (ioRdata[7:6] == 2'b00)) else $error("address reserved bits not zero");
    AST_WR_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        wrAccept |=> wrStrobe_r [*8]) else $error("write strobe dropped early");
    AST_WR_END: assert property (@(posedge mclk) disable iff (!rstn)
        (wrStrobe_r && wrCnt_r == WR_CNT_W'(1)) |=> !wrStrobe_r) else $error("write strobe not cleared");
    AST_BUSY_IGN: assert property (@(posedge mclk) disable iff (!rstn)
        (wrStrobe_r && ctrlWr) |=> ($stable(stall_r) || stall_r == $past(stall_r) - 3'h1))
        else $error("strobe accepted during write");

    AST_WR_TIME: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(wrStrobe_r) |-> (wrAge_r == wrLen_r))
        else $error("write time not as loaded");
    AST_WR_LEN: assert property (@(posedge mclk) disable iff (!rstn)
        wrAccept |=> (wrLen_r == ($past(lowSync_r) ? WR_CNT_W'(WR_CYCLES_LO) : WR_CNT_W'(WR_CYCLES_HI))))
        else $error("write time not matched to supply");
    AST_RD_DONE: assert property (@(posedge mclk) disable iff (!rstn)
        rdAccept |=> ##1 sRdDone)
        else $error("read not done within one instruction");
    AST_RD_IGN: assert property (@(posedge mclk) disable iff (!rstn)
        (wrStrobe_r && ctrlWr) |=> !rdStrobe_r)
        else $error("read strobe accepted during write");
    AST_ADDR_WR: assert property (@(posedge mclk) disable iff (!rstn)
        (ioWe && selAddr) |=> (addr_r == $past(ioWdata[ADDR_W-1:0])))
        else $error("address field not written");
    AST_DATA_WR: assert property (@(posedge mclk) disable iff (!rstn)
        (ioWe && selData && !rdStrobe_r) |=> (data_r == $past(ioWdata)))
        else $error("data register not written");
    AST_DATA_RD: assert property (@(posedge mclk) disable iff (!rstn)
        (ioRe && selData) |=> (ioRdata == $past(data_r)))
        else $error("data register read wrong");
    AST_CTRL_VAL: assert property (@(posedge mclk) disable iff (!rstn)
        (ioRe && selCtrl) |=> (ioRdata[1:0] == $past({wrStrobe_r, rdStrobe_r})))
        else $error("control strobe bits read wrong");
    AST_UNMAP_RD: assert property (@(posedge mclk) disable iff (!rstn)
        (ioRe && !selAddr && !selData && !selCtrl) |=> (ioRdata == 8'h00))
        else $error("unmapped read not zero");
    AST_STALL_MAX: assert property (@(posedge mclk) disable iff (!rstn)
        stall_r <= RD_STALL)
        else $error("stall counter out of range");
    AST_RST_IDLE: assert property (@(posedge mclk)
        !rstn |-> (!cpuStall && !wrStrobe_r && ioRdata == 8'h00))
        else $error("outputs not idle in reset");
endmodule : eac_access_ctrl

//--- test/eac_core_model.sv
// Purpose: Core model issuing I/O register accesses
// Assumes: One access at a time, stall cycles absorbed
// Notes:   Drives after rising edges, samples 1 ns later
`timescale 1ns/1ps
module eac_core_model
    import eac_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // I/O register port
    output logic      [5:0] ioAddr,
    output logic            ioWe,
    output logic            ioRe,
    output logic      [7:0] ioWdata,
    input  wire logic [7:0] ioRdata,
    input  wire logic       cpuStall
);
    initial begin
        ioAddr  = 6'h00;
        ioWe    = 1'b0;
        ioRe    = 1'b0;
        ioWdata = 8'h00;
    end
    task automatic acc(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q, output int n);
        @(posedge mclk);
        ioAddr  <= a;
        ioWdata <= d;
        ioWe    <= we;
        ioRe    <= !we;
        @(posedge mclk);
        ioWe    <= 1'b0;
        ioRe    <= 1'b0;
        ioWdata <= ~d;
        #1;
        q = ioRdata;
        n = 0;
        while (cpuStall === 1'b1) begin
            n++;
            @(posedge mclk);
            #1;
        end
    endtask : acc
    task automatic poll;
        logic [7:0] q;
        int         n;
        q = 8'h02;
        while (q[WR_BIT] !== 1'b0) begin
            acc(1'b0, CTRL_OFS, 8'h00, q, n);
        end
    endtask : poll
endmodule : eac_core_model

//--- test/eac_access_ctrl_tb.sv
// Purpose: Self-checking bench for the access controller
// Assumes: Short write times set by parameter
// Notes:   Addresses 0 and 63 then random ones, random data from a fixed seed
`timescale 1ns/1ps
module eac_access_ctrl_tb;
    import eac_pkg::*;
    localparam int HI = 20;
    localparam int LO = 30;
    logic       mclk;
    logic       rstn;
    logic       lowSupply;
    logic [5:0] ioAddr;
    logic       ioWe;
    logic       ioRe;
    logic [7:0] ioWdata;
    logic [7:0] ioRdata;
    logic       cpuStall;
    logic [7:0] q;
    logic [7:0] mem [64];
    logic [5:0] aq [6];
    int         n;
    int         i;
    int         e;
    int         cyc = 0;
    int         seed = 71;
    int         failures = 0;
    int         checked = 0;
    eac_access_ctrl #(.WR_CYCLES_HI(HI), .WR_CYCLES_LO(LO)) eac_access_ctrl_inst (.mclk(mclk), .rstn(rstn),
        .ioAddr(ioAddr), .ioWe(ioWe), .ioRe(ioRe), .ioWdata(ioWdata), .ioRdata(ioRdata),
        .cpuStall(cpuStall), .lowSupply(lowSupply));
    eac_core_model eac_core_model_inst (.mclk(mclk), .ioAddr(ioAddr), .ioWe(ioWe), .ioRe(ioRe),
        .ioWdata(ioWdata), .ioRdata(ioRdata), .cpuStall(cpuStall));
    always #10 mclk = ~mclk;
    function automatic int wtime(input logic lo);
        return lo ? LO : HI;
    endfunction : wtime
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        mclk      = 1'b0;
        rstn      = 1'b0;
        lowSupply = 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        eac_core_model_inst.acc(1'b0, CTRL_OFS, 8'h00, q, n);
        chk(q, REG_RST);
        eac_core_model_inst.acc(1'b1, ADDR_OFS, 8'hFF, q, n);
        eac_core_model_inst.acc(1'b0, ADDR_OFS, 8'h00, q, n);
        chk(q, 8'h3F);
        eac_core_model_inst.acc(1'b0, 6'h00, 8'h00, q, n);
        chk(q, 8'h00);
        for (i = 0; i < 6; i++) begin
            lowSupply <= i[0];
            aq[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
            mem[aq[i]] = 8'($random(seed));
            eac_core_model_inst.acc(1'b1, ADDR_OFS, {2'b00, aq[i]}, q, n);
            eac_core_model_inst.acc(1'b1, DATA_OFS, mem[aq[i]], q, n);
            e = cyc;
            eac_core_model_inst.acc(1'b1, CTRL_OFS, 8'hFF, q, n);
            chk(8'(n), 8'(WR_STALL));
            eac_core_model_inst.acc(1'b0, CTRL_OFS, 8'h00, q, n);
            chk(q, 8'h02);
            eac_core_model_inst.acc(1'b1, CTRL_OFS, 8'h01, q, n);
            chk(8'(n), 8'h00);
            eac_core_model_inst.acc(1'b1, CTRL_OFS, 8'h02, q, n);
            chk(8'(n), 8'h00);
            eac_core_model_inst.poll();
            e = cyc - e;
            chk({7'h00, e >= wtime(i[0]) && e <= wtime(i[0]) + 8}, 8'h01);
        end
        for (i = 0; i < 6; i++) begin
            eac_core_model_inst.acc(1'b1, ADDR_OFS, {2'b00, aq[i]}, q, n);
            eac_core_model_inst.acc(1'b1, CTRL_OFS, 8'h01, q, n);
            chk(8'(n), 8'(RD_STALL));
            eac_core_model_inst.acc(1'b0, CTRL_OFS, 8'h00, q, n);
            chk(q, 8'h00);
            eac_core_model_inst.acc(1'b0, DATA_OFS, 8'h00, q, n);
            chk(q, mem[aq[i]]);
        end
        lowSupply <= 1'b1;
        repeat (8) @(posedge mclk);
        eac_core_model_inst.acc(1'b0, CTRL_OFS, 8'h00, q, n);
        chk(q, 8'h00);
        summarize();
    end
endmodule : eac_access_ctrl_tb
